// ### mde_pkg.sv
// constants, opcodes and register map of the opcode decode/execute core
package mde_pkg;
  localparam int IW_W = 13;
  localparam int PC_W = 11;
  localparam int DW = 8;
  // fixed control opcodes
  localparam logic [IW_W-1:0] OP_NOP = 13'h0000;
  localparam logic [IW_W-1:0] OP_DAA = 13'h0001;
  localparam logic [IW_W-1:0] OP_CLEAR_ACCUMULATOR = 13'h0080;
  localparam logic [5:0] LO_DAA = 6'h01;
  localparam logic [5:0] LO_WRITE_CONTROL_FROM_ACC = 6'h02;
  localparam logic [5:0] LO_SLEEP = 6'h03;
  localparam logic [5:0] LO_WATCHDOG_CLEAR = 6'h04;
  localparam logic [5:0] LO_ENI = 6'h10;
  localparam logic [5:0] LO_INTERRUPT_DISABLE_OP = 6'h11;
  localparam logic [5:0] LO_RET = 6'h12;
  localparam logic [5:0] LO_RETURN_ENABLE_IRQ = 6'h13;
  localparam logic [5:0] LO_READ_CONTROL_TO_ACC = 6'h14;
  localparam logic [5:0] LO_TBL = 6'h20;
  // register-operand groups, instruction bits 12:6
  localparam logic [6:0] G_CTRL = 7'h00;
  localparam logic [6:0] G_MOVRA = 7'h01;
  localparam logic [6:0] G_CLEAR_ACCUMULATOR = 7'h02;
  localparam logic [6:0] G_CLRR = 7'h03;
  localparam logic [6:0] G_MOVAR = 7'h10;
  // bit ops and literals, instruction bits 12:9, 12:10 and 12:8
  localparam logic [3:0] B_CLR = 4'h4;
  localparam logic [3:0] B_SET = 4'h5;
  localparam logic [3:0] B_TSTC = 4'h6;
  localparam logic [3:0] B_TSTS = 4'h7;
  localparam logic [2:0] L_CALL = 3'h4;
  localparam logic [2:0] L_JMP = 3'h5;
  localparam logic [4:0] L_MOVK = 5'h18;
  // register map and status layout
  localparam logic [5:0] ADDR_PCL = 6'h02;
  localparam logic [5:0] ADDR_STATUS = 6'h03;
  localparam logic [5:0] ADDR_SEL = 6'h04;
  localparam logic [5:0] ADDR_BANKED = 6'h10;
  localparam logic [5:0] ADDR_COMMON = 6'h20;
  localparam int GP_N = 96;
  localparam int BANKED_N = 64;
  localparam int ST_C = 0;
  localparam int ST_DC = 1;
  localparam int ST_Z = 2;
  localparam int ST_P = 3;
  localparam int ST_T = 4;
  localparam int SEL_BANK_LO = 6;
  localparam logic [DW-1:0] STATUS_RST = 8'h18;
  localparam logic [3:0] BCD_MAX = 4'h9;
  localparam logic [DW-1:0] DAA_LO = 8'h06;
  localparam logic [DW-1:0] DAA_HI = 8'h60;
endpackage

// ### mde_core.sv
// opcode decode and execute core with register file, stack and flags
`timescale 1ns/100ps
module mde_core import mde_pkg::*; #(
  parameter int STACK_DEPTH = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // program memory
  output logic [PC_W-1:0] pc_q,
  input wire logic [IW_W-1:0] instr,
  // register-mapped i/o (addresses below 10h except 2..4)
  output logic [5:0] io_sel_q,
  output logic io_we_q,
  output logic [DW-1:0] io_wdata_q,
  input wire logic [DW-1:0] io_rdata,
  // i/o control registers
  output logic [3:0] ioc_sel_q,
  output logic ioc_we_q,
  output logic [DW-1:0] ioc_wdata_q,
  input wire logic [DW-1:0] ioc_rdata,
  // core state
  output logic [DW-1:0] acc_q,
  output logic [DW-1:0] status_q,
  output logic [DW-1:0] control_register_q,
  output logic gie_q,
  output logic sleep_q,
  output logic wdt_clear_q,
  // wake-up pin
  input wire logic wake
);
  localparam int SP_W = $clog2(STACK_DEPTH);

  // elaboration check: the stack pointer wraps, so the depth must be a power of two
  if (STACK_DEPTH < 2 || (1 << SP_W) != STACK_DEPTH) begin : g_depth_check
    $error("STACK_DEPTH must be a power of two");
  end

  logic phase_q, kill_q, exec;
  logic [IW_W-1:0] ir_q;
  logic [DW-1:0] sel_q;
  logic [DW-1:0] gp_q [0:GP_N-1];
  logic [PC_W-1:0] stk_q [0:STACK_DEPTH-1];
  logic [SP_W-1:0] sp_q;
  logic [2:0] wake_s;
  logic [5:0] ra;
  logic [6:0] gidx;
  logic [DW-1:0] rd, res, add_x, add_y, bmask;
  logic [8:0] sum9;
  logic [4:0] sum5;
  logic is_sub, is_tbl;
  logic a_we, r_we, z_we, c_we, dc_we, c_val, dc_val;
  logic ioc_we_d, control_register_we, slp, wdc, gie_set, gie_clr;
  logic push, pop, jump, skip;
  logic [PC_W-1:0] jtarget;

  // instruction cycle: phase 0 fetches, phase 1 executes
  assign exec = phase_q & ~kill_q & ~sleep_q;
  assign ra = ir_q[5:0];
  // banked window uses select bits 7:6, upper window is common
  assign gidx = (ra < ADDR_COMMON) ? {1'b0, sel_q[SEL_BANK_LO+1:SEL_BANK_LO], ra[3:0]}
                                   : 7'(BANKED_N) + {2'b00, ra[4:0]};

  // operand read, i/o space reads like any register
  always_comb begin
    if (ra == ADDR_PCL) begin
      rd = pc_q[DW-1:0];
    end else if (ra == ADDR_STATUS) begin
      rd = status_q;
    end else if (ra == ADDR_SEL) begin
      rd = sel_q;
    end else if (ra < ADDR_BANKED) begin
      rd = io_rdata;
    end else begin
      rd = gp_q[gidx];
    end
  end

  // shared adder for add, subtract and table jump
  always_comb begin
    is_sub = (ir_q[12:7] == 6'h02);
    is_tbl = (ir_q[12:6] == G_CTRL) && (ra == LO_TBL);
    add_x = is_tbl ? pc_q[DW-1:0] : rd;
    add_y = is_sub ? ~acc_q : acc_q;
    sum9 = {1'b0, add_x} + {1'b0, add_y} + {8'h00, is_sub};
    sum5 = {1'b0, add_x[3:0]} + {1'b0, add_y[3:0]} + {4'h0, is_sub};
    bmask = 8'(1) << ir_q[8:6];
  end

  // decode and execute
  always_comb begin
    res = acc_q;
    a_we = 1'b0;
    r_we = 1'b0;
    z_we = 1'b0;
    c_we = 1'b0;
    dc_we = 1'b0;
    c_val = sum9[8];
    dc_val = sum5[4];
    ioc_we_d = 1'b0;
    control_register_we = 1'b0;
    slp = 1'b0;
    wdc = 1'b0;
    gie_set = 1'b0;
    gie_clr = 1'b0;
    push = 1'b0;
    pop = 1'b0;
    jump = 1'b0;
    skip = 1'b0;
    jtarget = pc_q;
    if (exec) begin
      if (ir_q == OP_NOP) begin
        res = acc_q;
      end else if (ir_q[12:6] == G_CTRL) begin
        // exact control codes are listed before the indexed moves
        casez (ra)
          LO_DAA: begin
            res = acc_q;
            c_val = status_q[ST_C];
            if (acc_q[3:0] > BCD_MAX) begin
              res = res + DAA_LO;
            end
            if (acc_q > {BCD_MAX, BCD_MAX} || status_q[ST_C]) begin
              res = res + DAA_HI;
              c_val = 1'b1;
            end
            a_we = 1'b1;
            c_we = 1'b1;
          end
          LO_WRITE_CONTROL_FROM_ACC: control_register_we = 1'b1;
          LO_SLEEP: begin
            slp = 1'b1;
            wdc = 1'b1;
          end
          LO_WATCHDOG_CLEAR: wdc = 1'b1;
          LO_ENI: gie_set = 1'b1;
          LO_INTERRUPT_DISABLE_OP: gie_clr = 1'b1;
          LO_RET, LO_RETURN_ENABLE_IRQ: begin
            pop = 1'b1;
            jump = 1'b1;
            jtarget = stk_q[sp_q - SP_W'(1)];
            gie_set = ra[0];
          end
          LO_READ_CONTROL_TO_ACC: begin
            res = control_register_q;
            a_we = 1'b1;
          end
          LO_TBL: begin
            res = sum9[DW-1:0];
            jump = 1'b1;
            jtarget = {pc_q[PC_W-1:9], sum9};
            z_we = 1'b1;
            c_we = 1'b1;
            dc_we = 1'b1;
          end
          6'b00????: ioc_we_d = 1'b1;
          6'b01????: begin
            res = ioc_rdata;
            a_we = 1'b1;
          end
          default: res = acc_q;
        endcase
      end else if (ir_q[12] == 1'b0 && ir_q[11:10] == 2'b00) begin
        // accumulator and register operations, bit 6 picks the register as target
        a_we = ~ir_q[6];
        r_we = ir_q[6];
        z_we = 1'b1;
        unique case (ir_q[9:7])
          3'h0: begin
            res = acc_q;
            z_we = 1'b0;
          end
          3'h1: begin
            res = 8'h00;
            a_we = (ir_q == OP_CLEAR_ACCUMULATOR);
            z_we = a_we | r_we;
          end
          3'h2: begin
            res = sum9[DW-1:0];
            c_we = 1'b1;
            dc_we = 1'b1;
          end
          3'h3: res = rd + 8'hff;
          3'h4: res = acc_q | rd;
          3'h5: res = acc_q & rd;
          3'h6: res = acc_q ^ rd;
          3'h7: begin
            res = sum9[DW-1:0];
            c_we = 1'b1;
            dc_we = 1'b1;
          end
        endcase
      end else if (ir_q[12:6] == G_MOVAR) begin
        res = rd;
        a_we = 1'b1;
        z_we = 1'b1;
      end else if (ir_q[12] == 1'b0 && ir_q[11] == 1'b1) begin
        unique case (ir_q[12:9])
          B_CLR: begin
            res = rd & ~bmask;
            r_we = 1'b1;
          end
          B_SET: begin
            res = rd | bmask;
            r_we = 1'b1;
          end
          B_TSTC: skip = ((rd & bmask) == 8'h00);
          default: skip = ((rd & bmask) != 8'h00);
        endcase
      end else if (ir_q[12:10] == L_CALL || ir_q[12:10] == L_JMP) begin
        push = (ir_q[12:10] == L_CALL);
        jump = 1'b1;
        jtarget = {pc_q[PC_W-1:10], ir_q[9:0]};
      end else if (ir_q[12:8] == L_MOVK) begin
        res = ir_q[7:0];
        a_we = 1'b1;
      end
      if (r_we && ra == ADDR_PCL) begin
        jump = 1'b1;
        jtarget = {pc_q[PC_W-1:DW], res};
      end
    end
  end

  // wake pin: three flops, wake taken once stages 2 and 3 are both high
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wake_s <= 3'b000;
    end else begin
      wake_s <= {wake_s[1:0], wake};
    end
  end

  // phase, fetch and flush of the cycle after a jump or skip
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      phase_q <= 1'b0;
      kill_q <= 1'b0;
      ir_q <= OP_NOP;
      io_sel_q <= 6'h00;
      ioc_sel_q <= 4'h0;
    end else if (!sleep_q) begin
      phase_q <= ~phase_q;
      if (phase_q) begin
        kill_q <= exec & (jump | skip);
      end else begin
        ir_q <= instr;
        io_sel_q <= instr[5:0];
        ioc_sel_q <= instr[3:0];
      end
    end
  end

  // program counter and return stack
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pc_q <= '0;
      sp_q <= '0;
    end else begin
      // a flushed fetch leaves pc alone, so a jump lands on its target and a skip steps over one word
      if (!sleep_q && !phase_q && !kill_q) begin
        pc_q <= pc_q + PC_W'(1);
      end else if (jump) begin
        pc_q <= jtarget;
      end else if (skip) begin
        pc_q <= pc_q + PC_W'(1);
      end
      if (push) begin
        stk_q[sp_q] <= pc_q;
        sp_q <= sp_q + SP_W'(1);
      end else if (pop) begin
        sp_q <= sp_q - SP_W'(1);
      end
    end
  end

  // accumulator, control register, select register, register file
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      acc_q <= 8'h00;
      control_register_q <= 8'h00;
      sel_q <= 8'h00;
      io_we_q <= 1'b0;
      io_wdata_q <= 8'h00;
      ioc_we_q <= 1'b0;
      ioc_wdata_q <= 8'h00;
    end else begin
      if (a_we) begin
        acc_q <= res;
      end
      if (control_register_we) begin
        control_register_q <= acc_q;
      end
      if (r_we && ra == ADDR_SEL) begin
        sel_q <= res;
      end
      if (r_we && ra >= ADDR_BANKED) begin
        gp_q[gidx] <= res;
      end
      io_we_q <= r_we && ra < ADDR_BANKED && ra != ADDR_PCL && ra != ADDR_STATUS && ra != ADDR_SEL;
      io_wdata_q <= res;
      ioc_we_q <= ioc_we_d;
      ioc_wdata_q <= acc_q;
    end
  end

  // status flags: register write first, then affected flags only
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      status_q <= STATUS_RST;
    end else begin
      if (r_we && ra == ADDR_STATUS) begin
        status_q <= res;
      end
      if (z_we) begin
        status_q[ST_Z] <= (res == 8'h00);
      end
      if (c_we) begin
        status_q[ST_C] <= c_val;
      end
      if (dc_we) begin
        status_q[ST_DC] <= dc_val;
      end
      if (slp || wdc) begin
        status_q[ST_T] <= 1'b1;
        status_q[ST_P] <= ~slp;
      end
    end
  end

  // interrupt enable, sleep and watchdog clear pulse
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      gie_q <= 1'b0;
      sleep_q <= 1'b0;
      wdt_clear_q <= 1'b0;
    end else begin
      if (gie_set) begin
        gie_q <= 1'b1;
      end else if (gie_clr) begin
        gie_q <= 1'b0;
      end
      if (slp) begin
        sleep_q <= 1'b1;
      end else if (wake_s[1] && wake_s[2]) begin
        sleep_q <= 1'b0;
      end
      wdt_clear_q <= wdc;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_ret;
    exec && ir_q[12:6] == G_CTRL && (ra == LO_RET || ra == LO_RETURN_ENABLE_IRQ);
  endsequence
  sequence s_flush;
    kill_q [*2] ##1 !kill_q;
  endsequence
  property p_ret_two_cycles;
    s_ret |=> s_flush;
  endproperty
  a_ret_two_cycles: assert property (p_ret_two_cycles) else $error("return not flushed");
  property p_phase;
    !sleep_q |=> phase_q != $past(phase_q);
  endproperty
  a_phase: assert property (p_phase) else $error("phase did not toggle");
  property p_nop;
    exec && ir_q == OP_NOP |=> $stable(acc_q) && $stable(status_q);
  endproperty
  a_nop: assert property (p_nop) else $error("nop changed state");
  property p_write_control_from_acc;
    exec && ir_q[12:6] == G_CTRL && ra == LO_WRITE_CONTROL_FROM_ACC |=> control_register_q == $past(acc_q);
  endproperty
  a_write_control_from_acc: assert property (p_write_control_from_acc) else $error("control write wrong");
  property p_sleep;
    exec && ir_q[12:6] == G_CTRL && ra == LO_SLEEP |=> sleep_q && wdt_clear_q && !status_q[ST_P];
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep entry wrong");
  property p_watchdog_clear;
    exec && ir_q[12:6] == G_CTRL && ra == LO_WATCHDOG_CLEAR |=> wdt_clear_q && !sleep_q && status_q[ST_P];
  endproperty
  a_watchdog_clear: assert property (p_watchdog_clear) else $error("watchdog clear wrong");
  property p_eni;
    exec && ir_q[12:6] == G_CTRL && ra == LO_ENI |=> gie_q && $stable(status_q);
  endproperty
  a_eni: assert property (p_eni) else $error("enable interrupt wrong");
  property p_clear_accumulator;
    exec && ir_q == OP_CLEAR_ACCUMULATOR |=> acc_q == 8'h00 && status_q[ST_Z];
  endproperty
  a_clear_accumulator: assert property (p_clear_accumulator) else $error("clear accumulator wrong");
  property p_logic_keeps_carry;
    exec && ir_q[12:10] == 3'b000 && ir_q[9:8] != 2'b00 && ir_q[9:7] != 3'h2 && ir_q[9:7] != 3'h7
      && ra != ADDR_STATUS |=> $stable(status_q[ST_C]) && $stable(status_q[ST_DC]);
  endproperty
  a_logic_keeps_carry: assert property (p_logic_keeps_carry) else $error("carry changed");
endmodule // mde_core

// ### mde_prog_mem.sv
// program memory and i/o register model facing the decode/execute core
`timescale 1ns/100ps
module mde_prog_mem import mde_pkg::*; (
  // clock
  input wire logic clk,
  // program fetch
  input wire logic [PC_W-1:0] pc_q,
  output logic [IW_W-1:0] instr,
  // register-mapped i/o
  input wire logic [5:0] io_sel_q,
  input wire logic io_we_q,
  input wire logic [DW-1:0] io_wdata_q,
  output logic [DW-1:0] io_rdata,
  // i/o control registers
  input wire logic [3:0] ioc_sel_q,
  input wire logic ioc_we_q,
  input wire logic [DW-1:0] ioc_wdata_q,
  output logic [DW-1:0] ioc_rdata
);
  logic [IW_W-1:0] rom [0:1023];
  logic [DW-1:0] io_mem [0:63];
  logic [DW-1:0] ioc_mem [0:15];
  int n_ioc_we = 0;

  // start with cleared i/o state so a missed write reads back as zero
  initial begin
    for (int i = 0; i < 64; i++) io_mem[i] = 8'h00;
    for (int i = 0; i < 16; i++) ioc_mem[i] = 8'h00;
  end

  // fetch and read paths are combinational, valid before the execute edge
  assign instr = rom[pc_q[9:0]];
  assign io_rdata = io_mem[io_sel_q];
  assign ioc_rdata = ioc_mem[ioc_sel_q];

  // write strobes are one-cycle pulses, captured on the next edge
  always @(posedge clk) begin
    if (io_we_q === 1'b1) io_mem[io_sel_q] <= io_wdata_q;
    if (ioc_we_q === 1'b1) begin
      ioc_mem[ioc_sel_q] <= ioc_wdata_q;
      n_ioc_we <= n_ioc_we + 1;
    end
  end
endmodule // mde_prog_mem

// ### testbench.sv
// self-checking testbench of the opcode decode/execute core
`timescale 1ns/100ps
module testbench import mde_pkg::*; ;
  logic clk;
  logic sys_rst;
  logic wake;
  logic [PC_W-1:0] pc_q;
  logic [IW_W-1:0] instr;
  logic [5:0] io_sel_q;
  logic io_we_q;
  logic [DW-1:0] io_wdata_q;
  logic [DW-1:0] io_rdata;
  logic [3:0] ioc_sel_q;
  logic ioc_we_q;
  logic [DW-1:0] ioc_wdata_q;
  logic [DW-1:0] ioc_rdata;
  logic [DW-1:0] acc_q;
  logic [DW-1:0] status_q;
  logic [DW-1:0] control_register_q;
  logic gie_q;
  logic sleep_q;
  logic wdt_clear_q;
  int n_mismatch = 0;
  int n_compared = 0;
  int n_wdt = 0;

  // design under test and its program memory
  mde_core u_mde_core (.clk(clk), .sys_rst(sys_rst), .pc_q(pc_q), .instr(instr), .io_sel_q(io_sel_q),
    .io_we_q(io_we_q), .io_wdata_q(io_wdata_q), .io_rdata(io_rdata), .ioc_sel_q(ioc_sel_q),
    .ioc_we_q(ioc_we_q), .ioc_wdata_q(ioc_wdata_q), .ioc_rdata(ioc_rdata), .acc_q(acc_q),
    .status_q(status_q), .control_register_q(control_register_q), .gie_q(gie_q), .sleep_q(sleep_q),
    .wdt_clear_q(wdt_clear_q), .wake(wake));
  mde_prog_mem u_mde_prog_mem (.clk(clk), .pc_q(pc_q), .instr(instr), .io_sel_q(io_sel_q),
    .io_we_q(io_we_q), .io_wdata_q(io_wdata_q), .io_rdata(io_rdata), .ioc_sel_q(ioc_sel_q),
    .ioc_we_q(ioc_we_q), .ioc_wdata_q(ioc_wdata_q), .ioc_rdata(ioc_rdata));

  // 50 mhz clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // count watchdog clear pulses
  always @(posedge clk) begin
    if (wdt_clear_q === 1'b1) n_wdt <= n_wdt + 1;
  end

  task automatic check(input logic [12:0] got, input logic [12:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // hold reset 16 clocks and fill program memory with no-ops
  task automatic boot();
    @(posedge clk);
    sys_rst <= 1'b1;
    for (int i = 0; i < 1024; i++) u_mde_prog_mem.rom[i] = OP_NOP;
    repeat (16) @(posedge clk);
  endtask

  task automatic load(input int a, input logic [IW_W-1:0] w);
    u_mde_prog_mem.rom[a] = w;
  endtask

  // run n instruction slots of two clocks each, then look after the edge
  task automatic run(input int n);
    sys_rst <= 1'b0;
    repeat (2 * n) @(posedge clk);
    #1;
  endtask

  // load r into 20h, a into the accumulator, apply one register op
  task automatic alu_case(input logic [7:0] a, r, input logic [6:0] g, input logic [7:0] ea, es);
    boot();
    load(0, {5'h18, r});
    load(1, {G_MOVRA, 6'h20});
    load(2, {5'h18, a});
    load(3, {g, 6'h20});
    load(4, g[0] ? {G_MOVAR, 6'h20} : OP_NOP);
    run(5);
    check(acc_q, ea);
    check(status_q, es);
  endtask

  // no-op keeps state, pc advances once per two clocks
  task automatic t_nop();
    logic [PC_W-1:0] p;
    boot();
    run(1);
    p = pc_q;
    @(posedge clk);
    #1;
    check(pc_q, p + 11'h001);
    @(posedge clk);
    #1;
    check(pc_q, p + 11'h001);
    check(acc_q, 8'h00);
    check(status_q, STATUS_RST);
  endtask

  // decimal adjust, control register moves, i/o control moves, interrupt enable
  task automatic t_ctl();
    int w0;
    w0 = u_mde_prog_mem.n_ioc_we;
    boot();
    load(0, 13'h189a);
    load(1, OP_DAA);
    load(2, 13'h1855);
    load(3, {7'h00, LO_WRITE_CONTROL_FROM_ACC});
    load(4, 13'h0005);
    load(5, OP_CLEAR_ACCUMULATOR);
    load(6, {7'h00, LO_READ_CONTROL_TO_ACC});
    load(7, OP_CLEAR_ACCUMULATOR);
    load(8, 13'h0015);
    load(9, {7'h00, LO_ENI});
    load(10, {7'h00, LO_INTERRUPT_DISABLE_OP});
    load(11, {G_MOVRA, 6'h06});
    load(12, OP_CLEAR_ACCUMULATOR);
    load(13, {G_MOVAR, 6'h06});
    run(2);
    check(acc_q, 8'h00);
    check(status_q, 8'h19);
    run(4);
    check(control_register_q, 8'h55);
    check(acc_q, 8'h00);
    check(status_q, 8'h1d);
    check(u_mde_prog_mem.ioc_mem[5], 8'h55);
    check(u_mde_prog_mem.n_ioc_we - w0, 13'h0001);
    run(1);
    check(acc_q, 8'h55);
    check(status_q, 8'h1d);
    run(2);
    check(acc_q, 8'h55);
    run(1);
    check(gie_q, 1'b1);
    run(1);
    check(gie_q, 1'b0);
    check(status_q, 8'h1d);
    run(3);
    check(acc_q, 8'h55);
    check(u_mde_prog_mem.io_mem[6], 8'h55);
  endtask

  // call with a 10-bit target, return enabling interrupts, table jump
  task automatic t_flow();
    boot();
    load(0, 13'h1210);
    load(1, 13'h183c);
    load(12'h210, {7'h00, LO_RETURN_ENABLE_IRQ});
    run(4);
    check(acc_q, 8'h00);
    run(1);
    check(acc_q, 8'h3c);
    check(gie_q, 1'b1);
    boot();
    load(0, 13'h1802);
    load(1, {7'h00, LO_TBL});
    load(2, 13'h18ee);
    load(3, 13'h18ee);
    load(4, 13'h1877);
    run(4);
    check(acc_q, 8'h77);
    check(status_q, 8'h18);
  endtask

  // bit set, test-skip and clear, then bank select through the select register
  task automatic t_bits_bank();
    boot();
    load(0, 13'h1800);
    load(1, {G_MOVRA, 6'h20});
    load(2, {B_SET, 3'd3, 6'h20});
    load(3, {B_TSTS, 3'd3, 6'h20});
    load(4, 13'h18ee);
    load(5, {G_MOVAR, 6'h20});
    load(6, {B_CLR, 3'd3, 6'h20});
    load(7, {G_MOVAR, 6'h20});
    run(6);
    check(acc_q, 8'h08);
    run(2);
    check(acc_q, 8'h00);
    boot();
    load(0, 13'h1811);
    load(1, {G_MOVRA, 6'h10});
    load(2, 13'h1840);
    load(3, {G_MOVRA, ADDR_SEL});
    load(4, 13'h1822);
    load(5, {G_MOVRA, 6'h10});
    load(6, 13'h1800);
    load(7, {G_MOVRA, ADDR_SEL});
    load(8, {G_MOVAR, 6'h10});
    run(9);
    check(acc_q, 8'h11);
  endtask

  // sleep stops fetching until wake, watchdog clear pulses and status bits
  task automatic t_sleep();
    int w0;
    int k;
    w0 = n_wdt;
    boot();
    load(0, {7'h00, LO_SLEEP});
    load(1, {7'h00, LO_WATCHDOG_CLEAR});
    run(1);
    check(sleep_q, 1'b1);
    check(status_q, 8'h10);
    run(3);
    check(sleep_q, 1'b1);
    check(n_wdt - w0, 13'h0001);
    @(posedge clk) wake <= 1'b1;
    k = 0;
    while (sleep_q !== 1'b0 && k < 20) begin
      @(posedge clk);
      k++;
    end
    if (k == 20) begin
      n_mismatch++;
      results();
    end
    wake <= 1'b0;
    run(3);
    check(status_q, 8'h18);
    check(sleep_q, 1'b0);
    check(n_wdt - w0, 13'h0002);
  endtask

  // main sequence
  initial begin
    sys_rst = 1'b1;
    wake = 1'b0;
    t_nop();
    alu_case(8'h0c, 8'h35, 7'h04, 8'h29, 8'h19);
    alu_case(8'h0c, 8'h35, 7'h05, 8'h29, 8'h19);
    alu_case(8'h0c, 8'h35, 7'h06, 8'h34, 8'h18);
    alu_case(8'h0c, 8'h01, 7'h07, 8'h00, 8'h1c);
    alu_case(8'h0c, 8'h35, 7'h08, 8'h3d, 8'h18);
    alu_case(8'h00, 8'h00, 7'h09, 8'h00, 8'h1c);
    alu_case(8'hca, 8'h35, 7'h0a, 8'h00, 8'h1c);
    alu_case(8'h0c, 8'h35, 7'h0b, 8'h04, 8'h18);
    alu_case(8'h35, 8'h35, 7'h0c, 8'h00, 8'h1c);
    alu_case(8'h0c, 8'h35, 7'h0d, 8'h39, 8'h18);
    alu_case(8'h0c, 8'h35, 7'h0e, 8'h41, 8'h1a);
    alu_case(8'hf0, 8'h35, 7'h0f, 8'h25, 8'h19);
    alu_case(8'h0c, 8'h00, 7'h10, 8'h00, 8'h1c);
    alu_case(8'h0c, 8'h35, 7'h03, 8'h00, 8'h1c);
    t_ctl();
    t_flow();
    t_bits_bank();
    t_sleep();
    results();
  end
endmodule // testbench
